// >>> hw/hrtc_top.sv
// Function
// [RULE1] Chip select low with write strobe high is a memory read.
// [RULE2] Nineteen address lines pick one byte of 512K.
// [RULE3] Write spans later falling to earlier rising edge; host holds address.
// [RULE4] Falling write strobe turns off data outputs already driven.
// [RULE5] Power-fail blocks every memory and clock access.
// [RULE6] Host unlocks with 64 back-to-back writes on data lane zero.
// [RULE7] Before unlock, every access goes to the memory array.
// [RULE8] After unlock, next 64 cycles move clock data; memory suppressed.
// [RULE9] A read at any address starts matching at pattern bit 0.
// [RULE10] Unlock writes still store into the addressed memory byte.
// [RULE11] Writes compare to pattern bit at pointer; mismatch freezes matching.
// [RULE12] A read during matching restarts the pointer.
// [RULE13] Each of 64 clock cycles moves one bit on data lane zero.
// [RULE14] Cycles elsewhere do not disturb matching or transfer.
// [RULE15] Serial order runs bit 0 of register 0 to bit 7 of register 7.
// [RULE16] Timekeeping registers hold BCD digits.
// [RULE17] Host writes whole 8-bit groups; partial groups may corrupt.
// [RULE18] Hours bit 7 selects 12-hour when 1, 24-hour when 0.
// [RULE19] Hours bit 5 is afternoon flag or twenties digit.
// [RULE20] Day bit 4 gates abort input; low abort cancels transfer.
// [RULE21] Day bit 5 stops oscillator; bits 4 and 5 reset to 1.
// [RULE22] Unused bits of registers 1 to 6 read 0, writes discarded.
// [RULE23] Abort input is active low and idles high.
// [RULE24] Unlock pattern is a design parameter.
`timescale 1ns/10ps
`default_nettype none
`include "hrtc_params.svh"
module hrtc_top #(
    parameter int                     ADDR_W   = `HRTC_ADDR_W,
    parameter logic [`HRTC_PAT_BITS-1:0] PATTERN = `HRTC_PATTERN_DEF,
    parameter int                     TICK_CYC = `HRTC_CLK_HZ / `HRTC_TICK_HZ
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Memory bus
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [ADDR_W-1:0] byte_addr_lines,
    input  wire logic [7:0]        data_i,
    output logic [7:0]             data_o,
    output logic                   data_oe_n,
    // Supervision
    input  wire logic              abort_n,
    input  wire logic              power_fail_threshold
);
    localparam int CNT_W = $clog2(TICK_CYC);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (ADDR_W < 1 || ADDR_W > `HRTC_ADDR_W) begin : g_bad_addr
        $error("ADDR_W out of range");
    end
    if (TICK_CYC < 2) begin : g_bad_tick
        $error("TICK_CYC too small");
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [4:0]          ctl_s;
    logic [ADDR_W+7:0]   dat_s;
    logic                ce_l, oe_l, we_l, abort_l, pf;
    logic [ADDR_W-1:0]   addr_s;
    logic                data_lane_zero;

    // Abort idles high so a floating pin never aborts
    hrtc_sync #(.W(5), .RST_VAL(5'b11110)) u_sync_ctl ( // RULE23
        .core_clk (core_clk),
        .rst      (rst),
        .async_i  ({ce_n, oe_n, we_n, abort_n, power_fail_threshold}),
        .sync_q   (ctl_s)
    );
    hrtc_sync #(.W(ADDR_W + 8)) u_sync_dat (
        .core_clk (core_clk),
        .rst      (rst),
        .async_i  ({byte_addr_lines, data_i}),
        .sync_q   (dat_s)
    );

    assign ce_l           = ~ctl_s[4];
    assign oe_l           = ~ctl_s[3];
    assign we_l           = ~ctl_s[2];
    assign abort_l        = ~ctl_s[1];
    assign pf             = ctl_s[0];
    assign addr_s         = dat_s[ADDR_W+7:8];

    // ****************************************
    // Bus cycle detection
    // ****************************************
    logic              wr_act, ce_act, wr_ev, rd_ev;
    logic              wr_act_q, ce_act_q, seen_q, seen_d;
    logic [7:0]        wdat_q, wdat_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;

    // Only our own chip select opens a cycle; others pass unseen
    assign ce_act = ce_l & ~pf; // RULE5 RULE14
    assign wr_act = ce_act & we_l; // RULE3
    assign wr_ev  = wr_act_q & ~wr_act & ~pf; // RULE3
    // A chip-select period with no write counts as one read
    assign rd_ev  = ce_act_q & ~ce_act & ~seen_q & ~pf; // RULE1

    always_comb begin
        seen_d  = ce_act & (seen_q | wr_act);
        wdat_d  = wr_act ? dat_s[7:0] : wdat_q;
        waddr_d = wr_act ? addr_s : waddr_q; // RULE2
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_act_q <= 1'b0;
            ce_act_q <= 1'b0;
            seen_q   <= 1'b0;
            wdat_q   <= '0;
            waddr_q  <= '0;
        end else begin
            wr_act_q <= wr_act;
            ce_act_q <= ce_act;
            seen_q   <= seen_d;
            wdat_q   <= wdat_d;
            waddr_q  <= waddr_d;
        end
    end

    // Bit as held while the strobe was low; the lane may move as it ends
    assign data_lane_zero = wdat_q[0]; // RULE3 RULE13

    // ****************************************
    // Unlock and serial transfer
    // ****************************************
    hrtc_pkg::hrtc_state_t st_q, st_d;
    logic [`HRTC_PTR_W-1:0]   ptr_q, ptr_d;
    logic                     miss_q, miss_d, allw_q, allw_d;
    logic [`HRTC_PAT_BITS-1:0] sh_q, sh_d;
    logic                     abort_hit, commit, xfer_ev;
    logic [7:0]               commit_val;
    hrtc_pkg::hrtc_byte_t     tk_q [0:`HRTC_NUM_REGS-1];
    hrtc_pkg::hrtc_byte_t     tk_d [0:`HRTC_NUM_REGS-1];

    assign abort_hit = abort_l & ~tk_q[`HRTC_REG_DAY][`HRTC_DAY_GATE_BIT]; // RULE20
    assign xfer_ev   = (st_q == hrtc_pkg::st_xfer) & (wr_ev | rd_ev);
    assign commit    = (st_q == hrtc_pkg::st_xfer) & wr_ev & allw_q
                     & (ptr_q[2:0] == `HRTC_LAST_BIT) & ~abort_hit; // RULE17 RULE20
    assign commit_val = {data_lane_zero, sh_q[{ptr_q[5:3], 3'd0} +: 7]};

    always_comb begin
        st_d   = st_q;
        ptr_d  = ptr_q;
        miss_d = miss_q;
        allw_d = allw_q;
        sh_d   = sh_q;
        if (abort_hit && st_q != hrtc_pkg::st_locked) begin
            // Registers keep their value; pending byte is dropped
            st_d = hrtc_pkg::st_locked; // RULE20
        end else begin
            case (st_q)
                hrtc_pkg::st_locked: begin
                    if (rd_ev) begin
                        st_d   = hrtc_pkg::st_match; // RULE9
                        ptr_d  = '0;
                        miss_d = 1'b0;
                    end
                end
                hrtc_pkg::st_match: begin
                    if (rd_ev) begin
                        ptr_d  = '0; // RULE12
                        miss_d = 1'b0;
                    end else if (wr_ev && !miss_q) begin
                        if (data_lane_zero != PATTERN[ptr_q]) begin // RULE24
                            miss_d = 1'b1; // RULE11
                        end else if (ptr_q == '1) begin
                            st_d   = hrtc_pkg::st_xfer; // RULE8
                            ptr_d  = '0;
                            allw_d = 1'b1;
                            for (int i = 0; i < `HRTC_NUM_REGS; i++) begin
                                sh_d[i*8 +: 8] = tk_q[i];
                            end
                        end else begin
                            ptr_d = ptr_q + 1'b1; // RULE11
                        end
                    end
                end
                hrtc_pkg::st_xfer: begin
                    if (xfer_ev) begin
                        if (wr_ev) begin
                            sh_d[ptr_q] = data_lane_zero; // RULE13
                        end
                        allw_d = (ptr_q[2:0] == `HRTC_LAST_BIT) | (allw_q & wr_ev);
                        ptr_d  = ptr_q + 1'b1; // RULE15
                        if (ptr_q == '1) begin
                            st_d = hrtc_pkg::st_locked; // RULE13
                        end
                    end
                end
                default: st_d = hrtc_pkg::st_locked;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q   <= hrtc_pkg::st_locked;
            ptr_q  <= '0;
            miss_q <= 1'b0;
            allw_q <= 1'b0;
            sh_q   <= '0;
        end else begin
            st_q   <= st_d;
            ptr_q  <= ptr_d;
            miss_q <= miss_d;
            allw_q <= allw_d;
            sh_q   <= sh_d;
        end
    end

    // ****************************************
    // Memory array and read data
    // ****************************************
    logic              mem_we;
    logic [7:0]        mem_rdata;
    logic [7:0]        dout_q, dout_d;

    // Unlock writes still land in memory as a scratch byte
    assign mem_we = wr_ev & (st_q != hrtc_pkg::st_xfer); // RULE7 RULE8 RULE10

    hrtc_mem #(.ADDR_W(ADDR_W), .DATA_W(`HRTC_DATA_W)) u_mem (
        .core_clk (core_clk),
        .rst      (rst),
        .addr     (wr_ev ? waddr_q : addr_s),
        .we       (mem_we),
        .wdata    (wdat_q),
        .rdata_q  (mem_rdata)
    );

    always_comb begin
        if (st_q == hrtc_pkg::st_xfer) begin
            dout_d = {7'h00, sh_q[ptr_q]}; // RULE8 RULE13
        end else begin
            dout_d = mem_rdata; // RULE7
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dout_q <= '0;
        end else begin
            dout_q <= dout_d;
        end
    end

    assign data_o    = dout_q;
    // Drive only on a read with output enable; a write strobe wins
    assign data_oe_n = ~(ce_act & oe_l & ~we_l); // RULE1 RULE4 RULE5

    // ****************************************
    // Timekeeping
    // ****************************************
    logic [CNT_W-1:0] div_q, div_d;
    logic             tick, carry;
    logic [7:0]       mlen;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                           input logic [7:0] bot);
        if (v == top) begin
            return bot;
        end else if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0}; // RULE16
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] reg_mask(input logic [2:0] idx);
        case (idx)
            `HRTC_REG_SEC:   return `HRTC_MASK_SEC;
            `HRTC_REG_MIN:   return `HRTC_MASK_MIN;
            `HRTC_REG_HOUR:  return `HRTC_MASK_HOUR;
            `HRTC_REG_DAY:   return `HRTC_MASK_DAY;
            `HRTC_REG_DATE:  return `HRTC_MASK_DATE;
            `HRTC_REG_MONTH: return `HRTC_MASK_MONTH;
            default:         return `HRTC_MASK_FULL;
        endcase
    endfunction

    // Oscillator stop freezes the divider as well as the count
    assign tick = (div_q == CNT_W'(TICK_CYC - 1)) & ~tk_q[`HRTC_REG_DAY][`HRTC_DAY_OSC_BIT]; // RULE21

    always_comb begin
        logic [7:0] yr;
        logic       leap;
        yr   = tk_q[`HRTC_REG_YEAR];
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (tk_q[`HRTC_REG_MONTH])
            8'h02:                      mlen = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: mlen = 8'h30;
            default:                    mlen = 8'h31;
        endcase
    end

    always_comb begin
        logic [7:0] h;
        logic [7:0] h12;
        logic [7:0] h24;
        h     = tk_q[`HRTC_REG_HOUR];
        h12   = bcd_inc({3'b000, h[4:0]}, 8'h12, 8'h01);
        h24   = bcd_inc({2'b00, h[5:0]}, 8'h23, 8'h00);
        div_d = tk_q[`HRTC_REG_DAY][`HRTC_DAY_OSC_BIT] ? div_q
              : (tick ? '0 : div_q + 1'b1);
        for (int i = 0; i < `HRTC_NUM_REGS; i++) begin
            tk_d[i] = tk_q[i];
        end
        carry = tick;
        if (carry) begin
            tk_d[`HRTC_REG_HUND] = bcd_inc(tk_q[`HRTC_REG_HUND], 8'h99, 8'h00);
            carry = tk_q[`HRTC_REG_HUND] == 8'h99;
        end
        if (carry) begin
            tk_d[`HRTC_REG_SEC] = bcd_inc(tk_q[`HRTC_REG_SEC], 8'h59, 8'h00);
            carry = tk_q[`HRTC_REG_SEC] == 8'h59;
        end
        if (carry) begin
            tk_d[`HRTC_REG_MIN] = bcd_inc(tk_q[`HRTC_REG_MIN], 8'h59, 8'h00);
            carry = tk_q[`HRTC_REG_MIN] == 8'h59;
        end
        if (carry) begin
            if (h[`HRTC_HR_MODE_BIT]) begin // RULE18
                // 11 to 12 flips the afternoon flag
                if (h[4:0] == 5'h11) begin
                    tk_d[`HRTC_REG_HOUR] = {h[7:6], ~h[`HRTC_HR_PM_BIT], 5'h12}; // RULE19
                    carry = h[`HRTC_HR_PM_BIT];
                end else begin
                    tk_d[`HRTC_REG_HOUR] = {h[7:5], h12[4:0]};
                    carry = 1'b0;
                end
            end else begin
                // Bit 5 is the twenties digit here
                tk_d[`HRTC_REG_HOUR] = {h[7:6], h24[5:0]}; // RULE19
                carry = h[5:0] == 6'h23;
            end
        end
        if (carry) begin
            tk_d[`HRTC_REG_DAY] = {tk_q[`HRTC_REG_DAY][7:3],
                (tk_q[`HRTC_REG_DAY][2:0] == 3'd7) ? 3'd1 : tk_q[`HRTC_REG_DAY][2:0] + 3'd1};
            tk_d[`HRTC_REG_DATE] = bcd_inc(tk_q[`HRTC_REG_DATE], mlen, 8'h01);
            carry = tk_q[`HRTC_REG_DATE] == mlen;
        end
        if (carry) begin
            tk_d[`HRTC_REG_MONTH] = bcd_inc(tk_q[`HRTC_REG_MONTH], 8'h12, 8'h01);
            carry = tk_q[`HRTC_REG_MONTH] == 8'h12;
        end
        if (carry) begin
            tk_d[`HRTC_REG_YEAR] = bcd_inc(tk_q[`HRTC_REG_YEAR], 8'h99, 8'h00);
        end
        if (commit) begin
            // Host byte overrides any tick landing in the same cycle
            tk_d[ptr_q[5:3]] = commit_val & reg_mask(ptr_q[5:3]); // RULE22
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_q <= '0;
            for (int i = 0; i < `HRTC_NUM_REGS; i++) begin
                tk_q[i] <= `HRTC_RST_ZERO;
            end
            tk_q[`HRTC_REG_DAY]   <= `HRTC_RST_DAY; // RULE21
            tk_q[`HRTC_REG_DATE]  <= `HRTC_RST_DATE;
            tk_q[`HRTC_REG_MONTH] <= `HRTC_RST_MONTH;
        end else begin
            div_q <= div_d;
            for (int i = 0; i < `HRTC_NUM_REGS; i++) begin
                tk_q[i] <= tk_d[i];
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_PF_NO_DRIVE: assert property (pf |-> data_oe_n && !mem_we) // RULE5
        else $error("access during power fail");
    AST_WE_OFF: assert property (ce_l && oe_l && $fell(ctl_s[2]) |-> data_oe_n) // RULE4
        else $error("outputs driven under write strobe");
    AST_START: assert property (st_q == hrtc_pkg::st_locked && rd_ev && !abort_hit // RULE9
                                |=> st_q == hrtc_pkg::st_match && ptr_q == '0)
        else $error("read did not start matching");
    AST_RD_RESTART: assert property (st_q == hrtc_pkg::st_match && rd_ev && !abort_hit // RULE12
                                     |=> ptr_q == '0 && !miss_q)
        else $error("read did not restart pointer");
    AST_MISS_HOLD: assert property (st_q == hrtc_pkg::st_match && miss_q && !rd_ev // RULE11
                                    |=> $stable(ptr_q) && st_q != hrtc_pkg::st_xfer)
        else $error("pointer moved after mismatch");
    AST_SCRATCH: assert property (st_q == hrtc_pkg::st_match && wr_ev |-> mem_we) // RULE10
        else $error("unlock write not stored");
    AST_XFER_NO_MEM: assert property (st_q == hrtc_pkg::st_xfer |-> !mem_we) // RULE8
        else $error("memory written during transfer");
    AST_XFER_END: assert property (st_q == hrtc_pkg::st_xfer && xfer_ev && ptr_q == '1 // RULE13
                                   |=> st_q == hrtc_pkg::st_locked)
        else $error("transfer did not end after 64 bits");
    AST_ABORT: assert property (abort_hit && st_q == hrtc_pkg::st_xfer // RULE20
                                |=> st_q == hrtc_pkg::st_locked
                                    && ($stable(tk_q[`HRTC_REG_SEC][6:0]) || $past(tick)))
        else $error("abort ignored");
    AST_ZERO_BITS: assert property ((tk_q[`HRTC_REG_HOUR] & ~`HRTC_MASK_HOUR) == 8'h00 // RULE22
                                    && (tk_q[`HRTC_REG_DAY] & ~`HRTC_MASK_DAY) == 8'h00)
        else $error("unused bit set");
    AST_BCD: assert property (tk_q[`HRTC_REG_HUND][3:0] <= 4'h9) // RULE16
        else $error("hundredths not BCD");

    COV_UNLOCK: cover property (st_q == hrtc_pkg::st_match ##1 st_q == hrtc_pkg::st_xfer);
    COV_ABORT: cover property (abort_hit && st_q == hrtc_pkg::st_xfer);
    COV_COMMIT: cover property (commit);
    COV_MIN_ROLL: cover property (tick && tk_q[`HRTC_REG_HUND] == 8'h99
                                  && tk_q[`HRTC_REG_SEC] == 8'h59 && tk_q[`HRTC_REG_MIN] == 8'h59);
endmodule
`default_nettype wire

// >>> inc/hrtc_params.svh
`ifndef HRTC_PARAMS_SVH
`define HRTC_PARAMS_SVH

// ****************************************
// Bus geometry
// ****************************************
`define HRTC_ADDR_W        19
`define HRTC_DATA_W        8
`define HRTC_PAT_BITS      64
`define HRTC_PTR_W         6
`define HRTC_NUM_REGS      8
// Arbitrary unlock pattern, not tied to any real part
`define HRTC_PATTERN_DEF   64'h5ca3_3ac5_96e1_0f7b

// ****************************************
// Timing
// ****************************************
`define HRTC_CLK_HZ        25000000
`define HRTC_TICK_HZ       100

// ****************************************
// Clock register indices and fields
// ****************************************
`define HRTC_REG_HUND      3'd0
`define HRTC_REG_SEC       3'd1
`define HRTC_REG_MIN       3'd2
`define HRTC_REG_HOUR      3'd3
`define HRTC_REG_DAY       3'd4
`define HRTC_REG_DATE      3'd5
`define HRTC_REG_MONTH     3'd6
`define HRTC_REG_YEAR      3'd7
`define HRTC_HR_MODE_BIT   7
`define HRTC_HR_PM_BIT     5
`define HRTC_DAY_GATE_BIT  4
`define HRTC_DAY_OSC_BIT   5
`define HRTC_LAST_BIT      3'd7

// ****************************************
// Readable-bit masks and reset values
// ****************************************
`define HRTC_MASK_FULL     8'hff
`define HRTC_MASK_SEC      8'h7f
`define HRTC_MASK_MIN      8'h7f
`define HRTC_MASK_HOUR     8'hbf
`define HRTC_MASK_DAY      8'h37
`define HRTC_MASK_DATE     8'h3f
`define HRTC_MASK_MONTH    8'h1f
`define HRTC_RST_ZERO      8'h00
`define HRTC_RST_DAY       8'h31
`define HRTC_RST_DATE      8'h01
`define HRTC_RST_MONTH     8'h01

`endif

// >>> inc/hrtc_pkg.sv
`default_nettype none
package hrtc_pkg;
    typedef enum logic [1:0] {st_locked, st_match, st_xfer} hrtc_state_t;
    typedef logic [7:0] hrtc_byte_t;
endpackage
`default_nettype wire

// >>> hw/hrtc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module hrtc_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic [W-1:0]      sync_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> hw/hrtc_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "hrtc_params.svh"
module hrtc_mem #(
    parameter int ADDR_W = `HRTC_ADDR_W,
    parameter int DATA_W = `HRTC_DATA_W
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Single port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              we,
    input  wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0]      rdata_q
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rdata_d;

    always_comb rdata_d = mem[addr];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end
endmodule
`default_nettype wire

// >>> verification/hrtc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hrtc_host_model (
    // Clock
    input  wire logic       core_clk,
    // Bus pins
    output logic            ce_n,
    output logic            oe_n,
    output logic            we_n,
    output logic [18:0]     addr,
    output logic [7:0]      data,
    input  wire logic [7:0] data_o,
    input  wire logic       data_oe_n
);
    initial begin
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        addr = 19'h00000;
        data = 8'h00;
    end

    // ****************************************
    // One bus cycle: strobes 6 clocks, idle 4
    // ****************************************
    task automatic cyc(input logic w, input logic [18:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic drv_n);
        @(negedge core_clk);
        ce_n = 1'b0;
        we_n = !w;
        oe_n = w;
        addr = a;
        data = w ? d : ~data;
        repeat (6) @(negedge core_clk);
        q = data_o;
        drv_n = data_oe_n;
        ce_n = 1'b1;
        we_n = 1'b1;
        oe_n = 1'b1;
        // Released lane flips so a stale value is never mistaken for data
        data = ~data;
        repeat (4) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [63:0] PAT = 64'ha5c3_0f96_3c5a_e187;
    localparam logic [18:0] SCR = 19'h7ffff;
    localparam logic [63:0] IMG = 64'h0001_0137_b100_7f00;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        pf = 1'b0;
    logic        abort_n = 1'b1;
    logic        ce_n, oe_n, we_n, doe_n, dn;
    logic [18:0] addr;
    logic [7:0]  din, dout, q;
    logic [63:0] v;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #20 core_clk = ~core_clk;

    hrtc_top #(.ADDR_W(19), .PATTERN(PAT), .TICK_CYC(4)) hrtc_top_i (
        .core_clk(core_clk), .rst(rst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .byte_addr_lines(addr), .data_i(din), .data_o(dout), .data_oe_n(doe_n),
        .abort_n(abort_n), .power_fail_threshold(pf));

    hrtc_host_model hrtc_host_model_i (
        .core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .data(din), .data_o(dout), .data_oe_n(doe_n));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("Counts: %0d checks, %0d errors", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [18:0] a, input logic [7:0] d);
        hrtc_host_model_i.cyc(w, a, d, q, dn);
    endtask

    task automatic unlock;
        bus(1'b0, 19'h00000, 8'h00);
        for (int i = 0; i < 64; i++) bus(1'b1, SCR, {7'h00, PAT[i]});
    endtask

    task automatic xfer(input logic w, input logic [63:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            bus(w, 19'h00000, {7'h00, d[i]});
            v[i] = q[0];
        end
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        bus(1'b1, 19'h00000, 8'h3c);
        bus(1'b1, SCR, 8'hc3);
        bus(1'b0, 19'h00000, 8'h00);
        chk(q, 8'h3c);
        chk(dn, 1'b0);
        bus(1'b0, SCR, 8'h00);
        chk(q, 8'hc3);
        $display("Test memory done");
        unlock;
        xfer(1'b0, 64'h0, 64);
        chk(v, 64'h0001_0131_0000_0000);
        bus(1'b0, SCR, 8'h00);
        chk(q, {7'h00, PAT[63]});
        unlock;
        xfer(1'b1, 64'h0001_01ff_b100_ff00, 64);
        bus(1'b0, 19'h00000, 8'h00);
        chk(q, 8'h3c);
        $display("Test clock write done");
        bus(1'b1, SCR, {7'h00, ~PAT[0]});
        for (int i = 0; i < 64; i++) bus(1'b1, SCR, {7'h00, PAT[i]});
        bus(1'b0, 19'h00000, 8'h00);
        chk(q, 8'h3c);
        for (int i = 0; i < 32; i++) bus(1'b1, SCR, {7'h00, PAT[i]});
        unlock;
        xfer(1'b0, 64'h0, 64);
        chk(v, IMG);
        $display("Test pattern match done");
        unlock;
        xfer(1'b1, 64'h0001_0121_b100_0000, 64);
        unlock;
        xfer(1'b0, 64'h0, 8);
        abort_n = 1'b0;
        repeat (4) @(negedge core_clk);
        abort_n = 1'b1;
        bus(1'b0, 19'h00000, 8'h00);
        chk(q, 8'h3c);
        unlock;
        xfer(1'b0, 64'h0, 64);
        chk(v, 64'h0001_0121_b100_0000);
        $display("Test abort done");
        pf = 1'b1;
        bus(1'b1, 19'h00000, 8'hee);
        bus(1'b0, 19'h00000, 8'h00);
        chk(dn, 1'b1);
        pf = 1'b0;
        repeat (4) @(negedge core_clk);
        bus(1'b0, 19'h00000, 8'h00);
        chk(q, 8'h3c);
        $display("Test power fail done");
        // 11:59:59 PM with the oscillator on; rolls 100 ticks (400 clocks, 16 us) after the day byte lands
        unlock;
        xfer(1'b1, 64'h0102_2817_b159_5900, 64);
        unlock;
        xfer(1'b0, 64'h0, 64);
        chk(v[63:8], 56'h0103_0111_9200_01);
        $display("Test timekeeping done");
        end_sim;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 25000) begin
            errors++;
            $display("Error %0t: timeout", $time);
            end_sim;
        end
    end
endmodule
`default_nettype wire
